// ### rtl/ppsal_regs.sv
// Operation
// - event interrupt pin is active while any event status bit is set
// - once active the pin stays until the pending bits are cleared
// - status write clears bits written one, keeps bits written zero
// - bit 0 sets on every loop mode change; bits 15 to 1 reserved
// - reading event status returns it without changing it
// - pps output pulse lasts width setting microseconds, reset value 10
// - synth output is the stage clock divided by a 16-bit post divider
// - only 8 kHz multiple outputs are aligned to the pps rising edge
// - aligned frequency is low 17 bits n, giving n times 8 kHz
// - after loop start a build-out moves outputs toward pps alignment
// - default build-out rate 10 ps/s to 2.55 ns/s from rate setting
// - wide-range mode speeds up build-out, changes rate interpretation
// - config bit 0 aligns x chain, bit 1 aligns y chain
// - config bits 3:2 pick bandwidth shift speed; bits 7:4 reserved
// - alignment lines up chain, synth and pps outputs to pps edge
// - non run-time settings are ignored once the loop is kicked off
`timescale 1ns/100ps
module ppsal_regs #(
	parameter int MODE_W = 3,
	parameter int DIV_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// timing loop side
	input wire logic [MODE_W-1:0] timing_loop_mode,
	input wire logic pps_in,
	input wire logic stage_tick,
	input wire logic align_done,
	// event and clock outputs
	output logic event_irq_pin,
	output logic pps_out,
	output logic synth_out,
	// alignment control
	output logic loop_running,
	output logic x_align_en,
	output logic y_align_en,
	output ppsal_pkg::ppsal_bw_t bw_shift_speed,
	output logic [ppsal_pkg::FREQ_N_W-1:0] align_freq_n,
	output logic [15:0] buildout_step_ps,
	output logic buildout_step_valid,
	output logic [15:0] stage_setting
);
	import ppsal_pkg::*;

	logic [15:0] event_status_q, event_status_d;
	logic event_irq_q;
	logic [MODE_W-1:0] mode_q;
	logic mode_seen_q, mode_chg;
	logic run_q;
	logic [7:0] cfg_q, rate_q;
	logic wide_q;
	logic [47:0] freq_q;
	logic [11:0] pw_q;
	logic [15:0] stage_q;
	logic [DIV_W-1:0] div_q;
	logic pps_in_q, pps_rise;
	ppsal_loop_t loop_q;
	logic [15:0] step_q;
	logic step_vld_q;
	logic [7:0] rdata_q, rdata_d;
	logic cfg_wr_ok, evt_wr, align_ok;
	logic [7:0] freq_idx;

	assign evt_wr = reg_wr && reg_addr == ADDR_EVT_LO;
	assign cfg_wr_ok = reg_wr && !run_q;
	assign pps_rise = pps_in && !pps_in_q;
	assign mode_chg = mode_seen_q && timing_loop_mode != mode_q;
	assign freq_idx = reg_addr - ADDR_FREQ0;
	// a zero count means no 8 kHz multiple is set, so nothing aligns
	assign align_ok = run_q && (cfg_q[CFG_X_BIT] || cfg_q[CFG_Y_BIT]) &&
		freq_q[FREQ_N_W-1:0] != '0;

	// loop mode watcher
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_q <= '0;
			mode_seen_q <= 1'b0;
			pps_in_q <= 1'b0;
		end else begin
			mode_q <= timing_loop_mode;
			mode_seen_q <= 1'b1;
			pps_in_q <= pps_in;
		end
	end

	// event status: a change in the same cycle as a clear still lands
	always_comb begin
		event_status_d = event_status_q;
		if (evt_wr) begin
			event_status_d[7:0] = event_status_q[7:0] & ~reg_wdata;
		end
		if (mode_chg) begin
			event_status_d[EVT_MODE_BIT] = 1'b1;
		end
		event_status_d = event_status_d & EVT_MASK;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			event_status_q <= 16'h0000;
			event_irq_q <= 1'b0;
		end else begin
			event_status_q <= event_status_d;
			event_irq_q <= |event_status_d;
		end
	end

	// kickoff is sticky until reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_q <= 1'b0;
		end else if (reg_wr && reg_addr == ADDR_KICK &&
			reg_wdata[KICK_BIT]) begin
			run_q <= 1'b1;
		end
	end

	// setup registers, frozen after kickoff
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_q <= CFG_RESET;
			rate_q <= 8'h00;
			wide_q <= 1'b0;
			pw_q <= PW_RESET;
			stage_q <= 16'h0000;
			div_q <= DIV_W'(DIV_RESET);
		end else if (cfg_wr_ok) begin
			case (reg_addr)
				ADDR_CFG: cfg_q <= reg_wdata & CFG_MASK;
				ADDR_RATE: rate_q <= reg_wdata;
				ADDR_WIDE: wide_q <= reg_wdata[WIDE_BIT];
				ADDR_PW_LO: pw_q[7:0] <= reg_wdata;
				ADDR_PW_HI: pw_q[11:8] <= reg_wdata[3:0];
				ADDR_STG_LO: stage_q[7:0] <= reg_wdata;
				ADDR_STG_HI: stage_q[15:8] <= reg_wdata;
				ADDR_DIV_LO: div_q[7:0] <= reg_wdata;
				ADDR_DIV_HI: div_q[15:8] <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// run-time aligned frequency, writable at any time
	generate
		for (genvar b = 0; b < FREQ_BYTES; b++) begin : g_freq
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					freq_q[b*8 +: 8] <= 8'h00;
				end else if (reg_wr && freq_idx == 8'(b)) begin
					freq_q[b*8 +: 8] <= reg_wdata;
				end
			end
		end
	endgenerate

	// build-out sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			loop_q <= LOOP_IDLE;
		end else begin
			case (loop_q)
				LOOP_IDLE: if (align_ok) loop_q <= LOOP_BUILD;
				LOOP_BUILD: if (align_done) loop_q <= LOOP_ALIGNED;
				LOOP_ALIGNED: if (!align_done) loop_q <= LOOP_BUILD;
				default: loop_q <= LOOP_IDLE;
			endcase
		end
	end

	// one phase step per second; wide mode scales the same setting up
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			step_q <= 16'h0000;
			step_vld_q <= 1'b0;
		end else begin
			step_vld_q <= pps_rise && loop_q == LOOP_BUILD;
			if (pps_rise && loop_q == LOOP_BUILD) begin
				step_q <= wide_q ?
					16'((16'(rate_q) * 16'(RATE_STEP_PS)) << WIDE_SHIFT) :
					16'(16'(rate_q) * 16'(RATE_STEP_PS));
			end
		end
	end

	// read data, no side effect on any register
	always_comb begin
		rdata_d = 8'h00;
		case (reg_addr)
			ADDR_EVT_LO: rdata_d = event_status_q[7:0];
			ADDR_EVT_HI: rdata_d = event_status_q[15:8];
			ADDR_KICK: rdata_d = {7'h00, run_q};
			ADDR_CFG: rdata_d = cfg_q;
			ADDR_RATE: rdata_d = rate_q;
			ADDR_WIDE: rdata_d = {6'h00, loop_q == LOOP_ALIGNED, wide_q};
			ADDR_PW_LO: rdata_d = pw_q[7:0];
			ADDR_PW_HI: rdata_d = {4'h0, pw_q[11:8]};
			ADDR_STG_LO: rdata_d = stage_q[7:0];
			ADDR_STG_HI: rdata_d = stage_q[15:8];
			ADDR_DIV_LO: rdata_d = div_q[7:0];
			ADDR_DIV_HI: rdata_d = div_q[15:8];
			default: begin
				if (reg_addr >= ADDR_FREQ0 && reg_addr <= ADDR_FREQ5) begin
					rdata_d = freq_q[freq_idx[2:0]*8 +: 8];
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			rdata_q <= rdata_d;
		end
	end

	// registered so the enable pins never glitch on a config write
	logic x_en_q, y_en_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			x_en_q <= 1'b0;
			y_en_q <= 1'b0;
		end else begin
			x_en_q <= cfg_q[CFG_X_BIT] && align_ok;
			y_en_q <= cfg_q[CFG_Y_BIT] && align_ok;
		end
	end

	// output stages
	ppsal_pulse u_pulse (
		.clk(clk),
		.reset_n(reset_n),
		.pps_rise(pps_rise),
		.width_us(pw_q),
		.pps_out_q(pps_out)
	);

	ppsal_synth_div #(.DIV_W(DIV_W)) u_synth (
		.clk(clk),
		.reset_n(reset_n),
		.stage_tick(stage_tick),
		.post_div(div_q),
		.align_edge(pps_rise && align_ok),
		.synth_out_q(synth_out)
	);

	assign event_irq_pin = event_irq_q;
	assign reg_rdata = rdata_q;
	assign loop_running = run_q;
	assign x_align_en = x_en_q;
	assign y_align_en = y_en_q;
	assign bw_shift_speed = ppsal_bw_t'(cfg_q[CFG_BW_LSB +: 2]);
	assign align_freq_n = freq_q[FREQ_N_W-1:0];
	assign buildout_step_ps = step_q;
	assign buildout_step_valid = step_vld_q;
	assign stage_setting = stage_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_clear_all;
		evt_wr && !mode_chg && (event_status_q[7:0] & ~reg_wdata) == 8'h00;
	endsequence
	sequence s_build_pps;
		pps_rise && loop_q == LOOP_BUILD && !wide_q;
	endsequence
	AST_IRQ_LEVEL: assert property (event_irq_pin ==
		(event_status_q != 16'h0000)) else $error("irq differs from status");
	AST_IRQ_FALL: assert property ($fell(event_irq_pin) |->
		$past(evt_wr)) else $error("irq fell without a clearing write");
	AST_W1C: assert property (evt_wr && !mode_chg |=>
		event_status_q[7:0] == ($past(event_status_q[7:0]) &
		~$past(reg_wdata))) else $error("status clear is wrong");
	AST_CLEAR_IRQ: assert property (s_clear_all |=>
		!event_irq_pin) else $error("irq stayed after full clear");
	AST_MODE_SET: assert property (mode_chg |=> event_status_q[0] &&
		event_status_q[15:1] == 15'h0000) else $error("mode event lost");
	AST_READ_KEEP: assert property (reg_rd && !reg_wr && !mode_chg |=>
		$stable(event_status_q)) else $error("read changed status");
	AST_CFG_FROZEN: assert property (run_q && reg_wr |=>
		$stable(cfg_q) && $stable(pw_q) && $stable(rate_q))
		else $error("setup changed after kickoff");
	AST_STEP: assert property (s_build_pps |=> buildout_step_valid &&
		buildout_step_ps == 16'(16'($past(rate_q)) * 16'(RATE_STEP_PS)))
		else $error("build-out step wrong");
	AST_CFG_RSVD: assert property (cfg_q[7:4] == 4'h0)
		else $error("reserved config bits set");
	AST_BUILD_START: assert property (loop_q == LOOP_IDLE &&
		align_ok |=> loop_q == LOOP_BUILD)
		else $error("build-out did not start");
	AST_Y_OFF: assert property (!cfg_q[CFG_Y_BIT] |=> !y_align_en)
		else $error("y chain aligned while disabled");
endmodule : ppsal_regs

// ### rtl/ppsal_pkg.sv
package ppsal_pkg;
	// byte addresses of the register port
	localparam logic [7:0] ADDR_EVT_LO = 8'h07;
	localparam logic [7:0] ADDR_EVT_HI = 8'h08;
	localparam logic [7:0] ADDR_KICK = 8'h35;
	localparam logic [7:0] ADDR_CFG = 8'h45;
	localparam logic [7:0] ADDR_FREQ0 = 8'h46;
	localparam logic [7:0] ADDR_FREQ5 = 8'h4B;
	localparam logic [7:0] ADDR_RATE = 8'h4C;
	localparam logic [7:0] ADDR_WIDE = 8'h4D;
	localparam logic [7:0] ADDR_PW_LO = 8'hA0;
	localparam logic [7:0] ADDR_PW_HI = 8'hA1;
	localparam logic [7:0] ADDR_STG_LO = 8'hA7;
	localparam logic [7:0] ADDR_STG_HI = 8'hA8;
	localparam logic [7:0] ADDR_DIV_LO = 8'hA9;
	localparam logic [7:0] ADDR_DIV_HI = 8'hAA;
	// field layouts
	localparam int FREQ_BYTES = 6;
	localparam int FREQ_N_W = 17;
	localparam int CFG_X_BIT = 0;
	localparam int CFG_Y_BIT = 1;
	localparam int CFG_BW_LSB = 2;
	localparam int EVT_MODE_BIT = 0;
	localparam int KICK_BIT = 0;
	localparam int WIDE_BIT = 0;
	localparam logic [7:0] CFG_MASK = 8'h0F;
	localparam logic [15:0] EVT_MASK = 16'h0001;
	// reset values
	localparam logic [11:0] PW_RESET = 12'h00A;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [15:0] DIV_RESET = 16'h0001;
	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int US_NS = 1000;
	localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RATE_STEP_PS = 10;
	localparam int WIDE_SHIFT = 4;
	typedef enum logic [1:0] {
		BW_NORMAL = 2'b00,
		BW_SLOWER = 2'b01,
		BW_SLOWEST = 2'b10,
		BW_FASTER = 2'b11
	} ppsal_bw_t;
	typedef enum logic [1:0] {
		LOOP_IDLE = 2'b00,
		LOOP_BUILD = 2'b01,
		LOOP_ALIGNED = 2'b10
	} ppsal_loop_t;
endpackage : ppsal_pkg

// ### rtl/ppsal_pulse.sv
`timescale 1ns/100ps
module ppsal_pulse (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control
	input wire logic pps_rise,
	input wire logic [11:0] width_us,
	// output
	output logic pps_out_q
);
	import ppsal_pkg::*;
	localparam logic [7:0] US_LAST = 8'(CYC_PER_US - 1);
	logic [7:0] cyc_q;
	logic [11:0] us_q;
	logic [19:0] hi_len_q;

	// width counted in whole microseconds from the incoming edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pps_out_q <= 1'b0;
			cyc_q <= 8'h00;
			us_q <= 12'h000;
		end else if (pps_rise) begin
			pps_out_q <= (width_us != 12'h000);
			cyc_q <= 8'h00;
			us_q <= 12'h000;
		end else if (pps_out_q) begin
			if (cyc_q == US_LAST) begin
				cyc_q <= 8'h00;
				us_q <= us_q + 12'h001;
				if (us_q + 12'h001 >= width_us) begin
					pps_out_q <= 1'b0;
				end
			end else begin
				cyc_q <= cyc_q + 8'h01;
			end
		end
	end

	// cycles the pulse has stood since its start edge, for the length check
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hi_len_q <= 20'h00000;
		end else if (pps_rise) begin
			hi_len_q <= 20'h00000;
		end else if (pps_out_q) begin
			hi_len_q <= hi_len_q + 20'h00001;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_PW_START: assert property (pps_rise && width_us != 12'h000 |=>
		pps_out_q) else $error("pps pulse did not start");
	AST_PW_LEN: assert property ($fell(pps_out_q) &&
		!$past(pps_rise) |-> hi_len_q == 20'(width_us) * 20'(CYC_PER_US))
		else $error("pps pulse has wrong length");
endmodule : ppsal_pulse

// ### rtl/ppsal_synth_div.sv
`timescale 1ns/100ps
module ppsal_synth_div #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// stage tick and settings
	input wire logic stage_tick,
	input wire logic [DIV_W-1:0] post_div,
	input wire logic align_edge,
	// output
	output logic synth_out_q
);
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] div_eff;
	logic [DIV_W-1:0] half;

	// zero divider behaves as divide by one
	assign div_eff = (post_div == '0) ? DIV_W'(1) : post_div;
	// one extra bit so the largest divider does not wrap to zero
	assign half = DIV_W'(({1'b0, div_eff} + {{DIV_W{1'b0}}, 1'b1}) >> 1);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
			synth_out_q <= 1'b0;
		end else if (align_edge) begin
			cnt_q <= '0;
			synth_out_q <= 1'b1;
		end else if (stage_tick) begin
			if (cnt_q + DIV_W'(1) >= div_eff) begin
				cnt_q <= '0;
				synth_out_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + DIV_W'(1);
				synth_out_q <= (cnt_q + DIV_W'(1)) < half;
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_SYNTH_ALIGN: assert property (align_edge |=> synth_out_q &&
		cnt_q == '0) else $error("synth output not aligned to edge");
	AST_SYNTH_IDLE: assert property (!align_edge && !stage_tick |=>
		$stable(synth_out_q)) else $error("synth moved without a tick");
endmodule : ppsal_synth_div

// ### bench/ppsal_gnss_model.sv
`timescale 1ns/100ps
module ppsal_gnss_model (
	// clock
	input wire logic clk,
	// reference output
	output logic pps_in
);
	initial begin
		pps_in = 1'b0;
	end
	// receiver pulse is a few cycles wide, then idles low
	task automatic send(input int high_cyc);
		@(negedge clk);
		pps_in = 1'b1;
		repeat (high_cyc) @(negedge clk);
		pps_in = 1'b0;
	endtask : send
endmodule : ppsal_gnss_model

// ### bench/pps_event_align_regs_bench.sv
`timescale 1ns/100ps
module pps_event_align_regs_bench;
	import ppsal_pkg::*;
	logic clk, reset_n, reg_wr, reg_rd, pps_in, stage_tick, align_done;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
	logic [2:0] timing_loop_mode;
	logic event_irq_pin, pps_out, synth_out, loop_running;
	logic x_align_en, y_align_en, buildout_step_valid;
	ppsal_bw_t bw_shift_speed;
	logic [FREQ_N_W-1:0] align_freq_n;
	logic [15:0] buildout_step_ps, stage_setting, step_seen;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int hi_cnt;
	int syn_cnt;

	ppsal_regs i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .timing_loop_mode(timing_loop_mode),
		.pps_in(pps_in), .stage_tick(stage_tick), .align_done(align_done),
		.event_irq_pin(event_irq_pin), .pps_out(pps_out),
		.synth_out(synth_out), .loop_running(loop_running),
		.x_align_en(x_align_en), .y_align_en(y_align_en),
		.bw_shift_speed(bw_shift_speed), .align_freq_n(align_freq_n),
		.buildout_step_ps(buildout_step_ps),
		.buildout_step_valid(buildout_step_valid),
		.stage_setting(stage_setting));
	ppsal_gnss_model i_gnss (.clk(clk), .pps_in(pps_in));

	always #20 clk = ~clk;
	always @(negedge clk) stage_tick <= ~stage_tick;
	// step pulse lasts one cycle, so latch it for a later compare
	always @(posedge clk) begin
		if (buildout_step_valid === 1'b1) begin
			step_seen <= buildout_step_ps;
		end
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count = bad_count + 1;
			conclude();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
		check({8'h00, reg_rdata}, {8'h00, exp});
	endtask : rdc

	task automatic do_reset();
		@(negedge clk);
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
	endtask : do_reset

	task automatic conclude();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		timing_loop_mode = 3'd0;
		stage_tick = 1'b0;
		align_done = 1'b0;
		step_seen = 16'h0000;
		do_reset();
		rdc(ADDR_EVT_LO, 8'h00);
		rdc(ADDR_CFG, 8'h00);
		rdc(ADDR_FREQ0, 8'h00);
		rdc(8'h00, 8'h00);
		// mode change raises the only event source
		@(negedge clk);
		timing_loop_mode = 3'd5;
		repeat (2) @(negedge clk);
		check({15'h0, event_irq_pin}, 16'h0001);
		rdc(ADDR_EVT_LO, 8'h01);
		rdc(ADDR_EVT_LO, 8'h01);
		rdc(ADDR_EVT_HI, 8'h00);
		wr(ADDR_EVT_LO, 8'hFE);
		check({15'h0, event_irq_pin}, 16'h0001);
		wr(ADDR_EVT_LO, 8'h01);
		check({15'h0, event_irq_pin}, 16'h0000);
		rdc(ADDR_EVT_LO, 8'h00);
		$display("event test done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CFG, 8'hF0 | 8'(i << 2));
			rdc(ADDR_CFG, 8'(i << 2) & CFG_MASK);
			check({14'h0, bw_shift_speed}, 16'(i));
		end
		$display("config test done");
		// second pass uses wide mode, and resets in mid-run
		for (int w = 0; w < 2; w++) begin
			do_reset();
			check({15'h0, loop_running}, 16'h0000);
			rdc(ADDR_PW_LO, 8'h0A);
			wr(ADDR_PW_LO, 8'h01);
			wr(ADDR_PW_HI, 8'h00);
			wr(ADDR_STG_LO, 8'h34);
			wr(ADDR_STG_HI, 8'h12);
			wr(ADDR_DIV_LO, 8'h04);
			wr(ADDR_DIV_HI, 8'h00);
			// 24 kHz is the common frequency of all aligned outputs here
			wr(ADDR_FREQ0, 8'h03);
			for (int b = 1; b < FREQ_BYTES; b++) begin
				wr(8'(ADDR_FREQ0 + b), 8'h00);
			end
			wr(ADDR_RATE, 8'h05);
			wr(ADDR_WIDE, 8'(w));
			wr(ADDR_CFG, 8'h01);
			wr(ADDR_KICK, 8'h01);
			wr(ADDR_CFG, 8'h02);
			repeat (2) @(negedge clk);
			check(stage_setting, 16'h1234);
			rdc(ADDR_CFG, 8'h01);
			check({15'h0, loop_running}, 16'h0001);
			check({15'h0, x_align_en}, 16'h0001);
			check({15'h0, y_align_en}, 16'h0000);
			check(16'(align_freq_n), 16'h0003);
			step_seen = 16'h0000;
			hi_cnt = 0;
			syn_cnt = 0;
			fork
				i_gnss.send(3);
			join_none
			// divide by 4 of a tick every other cycle: half of 40 cycles high
			for (int k = 0; k < 41; k++) begin
				@(negedge clk);
				if (pps_out === 1'b1) hi_cnt = hi_cnt + 1;
				if (k == 1) check({15'h0, synth_out}, 16'h0001);
				if (k > 0 && synth_out === 1'b1) syn_cnt = syn_cnt + 1;
			end
			check(16'(hi_cnt), 16'(CYC_PER_US));
			check(16'(syn_cnt), 16'h0014);
			check(step_seen, 16'(50 << (WIDE_SHIFT * w)));
			align_done = 1'b1;
			rdc(ADDR_WIDE, 8'h02 | 8'(w));
			align_done = 1'b0;
			$display("alignment pass %0d done", w);
		end
		conclude();
	end
endmodule : pps_event_align_regs_bench
